//--- src/tccu_top.v
// Five capture/compare units against a 16-bit base timer, with register port
// Overview of operation
// - Five identical units, each with own registers
// - Capture copies 16-bit timer into value pair
// - Mode selects falling, rising, 4th, 16th edge
// - Capture sets flag; only software clears it
// - New capture overwrites unread old value
// - Source select picks one of eight sources
// - Pin level feeds capture even when output
// - Mode change may raise a spurious flag
// - Prescaler cleared when off, non-capture, reset
// - Prescaler switch alone does not clear counter
// - Sleep capture only while base timer runs
// - Compare value pair against timer, detect equality
// - Mode picks toggle, set, clear, trigger, interrupt
// - Match sets flag with pin action, trigger
// - Zero control write forces output latch low
// - Compare output also offered to peripherals
// - Match from selected unit triggers conversion
// - Match removed before reset edge cancels reset
// - Compare idle in sleep unless timer runs; wakes
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "tccu_defs.vh"

module tccu_top (
    input wire clock_in,
    input wire srst_in,
    input wire [4:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output wire [7:0] rdata_out,
    input wire [15:0] base_timer_count_in,
    input wire timer_running_in,
    input wire sleep_in,
    input wire [4:0] unit_pin_in,
    input wire comparator_one_sync_out_in,
    input wire comparator_two_sync_out_in,
    input wire pin_change_interrupt_in,
    input wire logic_cell_one_out_in,
    input wire logic_cell_two_out_in,
    input wire logic_cell_three_out_in,
    input wire logic_cell_four_out_in,
    output wire [4:0] compare_out,
    output wire [4:0] unit_event_flag_out,
    output wire [4:0] irq_out,
    output wire wake_out,
    output wire adc_trigger_out,
    output wire timer_reset_out
);
    // ================================================================
    // Mode decoding helpers
    // ================================================================

    // True for the four capture encodings
    function f_is_capture;
        input [3:0] mode;
        begin
            f_is_capture = (mode == `TCCU_MODE_CAP_FALL) || (mode == `TCCU_MODE_CAP_RISE) ||
                           (mode == `TCCU_MODE_CAP_RISE4) || (mode == `TCCU_MODE_CAP_RISE16);
        end
    endfunction

    // True for every compare encoding
    function f_is_compare;
        input [3:0] mode;
        begin
            f_is_compare = (mode == `TCCU_MODE_CMP_TOG_RST) || (mode == `TCCU_MODE_CMP_TOG) ||
                           (mode == `TCCU_MODE_CMP_SET) || (mode == `TCCU_MODE_CMP_CLR) ||
                           (mode == `TCCU_MODE_CMP_SWI) || (mode == `TCCU_MODE_CMP_TRIG);
        end
    endfunction

    // Word address of a per-unit register
    function [4:0] f_unit_addr;
        input integer unit;
        input [1:0] off;
        begin
            f_unit_addr = {unit[2:0], off};
        end
    endfunction

    // ================================================================
    // Shared state
    // ================================================================
    reg [4:0] flag_q; // Sticky event flags, one per unit
    reg [4:0] irq_en_q; // Interrupt enables
    reg [2:0] trig_sel_q; // 0 none, 1..5 selects unit for conversion trigger
    reg [7:0] rdata_q; // Registered read data
    reg [4:0] irq_q; // Gated interrupts
    reg wake_q; // Wake request during sleep
    reg adc_trig_q; // Conversion trigger pulse
    reg timer_rst_q; // Base timer reset pulse
    wire [4:0] event_w; // Capture or match events this cycle
    wire [4:0] match_w; // First-cycle match events per unit
    wire [4:0] rst_pend_w; // Reset pending per unit
    wire [4:0] latch_w; // Compare output latches
    wire [39:0] ctrl_w; // Control registers, flattened
    wire [14:0] src_w; // Source selects, flattened
    wire [79:0] val_w; // Value pairs, flattened

    // sleep gating
    // Events only count while awake or the timer keeps counting
    wire active_w = !sleep_in || timer_running_in;

    // shared sources
    // Seven shared sources; the unit pin fills slot zero per unit
    wire [6:0] shared_src_w = {logic_cell_four_out_in, logic_cell_three_out_in,
                               logic_cell_two_out_in, logic_cell_one_out_in,
                               pin_change_interrupt_in, comparator_two_sync_out_in,
                               comparator_one_sync_out_in};

    // ================================================================
    // Per-unit logic
    // ================================================================
    genvar gi;
    generate
        for (gi = 0; gi < `TCCU_UNITS; gi = gi + 1) begin : g_unit
            reg [7:0] ctrl_q; // Enable, format, mode
            reg [2:0] src_q; // Capture source select
            reg [15:0] val_q; // Value register pair
            reg prev_q; // Previous synchronised source level
            reg match_prev_q; // Equality seen last cycle
            reg latch_q; // Compare output latch
            reg rst_pend_q; // Reset owed after a trigger edge
            wire [7:0] srcs_w; // Eight selectable sources
            wire raw_w; // Selected unsynchronised source
            wire sync_w; // Synchronised source
            wire rise_w; // Rising edge
            wire fall_w; // Falling edge
            wire presc_fire_w; // Prescaler output
            wire [3:0] mode_w; // Operating mode field
            wire en_w; // Unit enable
            wire cap_mode_w; // In a capture mode
            wire cmp_mode_w; // In a compare mode
            wire cap_evt_w; // Qualified capture
            wire match_now_w; // Live equality
            wire match_evt_w; // First cycle of equality
            reg cap_sel_w; // Edge chosen by mode
            wire wr_ctrl_w;
            wire wr_src_w;
            wire wr_lo_w;
            wire wr_hi_w;

            assign mode_w = ctrl_q[3:0];
            assign en_w = ctrl_q[`TCCU_CTRL_EN_BIT];
            assign cap_mode_w = f_is_capture(mode_w);
            assign cmp_mode_w = f_is_compare(mode_w);
            assign wr_ctrl_w = wr_in && (addr_in == f_unit_addr(gi, `TCCU_OFF_CTRL));
            assign wr_src_w = wr_in && (addr_in == f_unit_addr(gi, `TCCU_OFF_SRC));
            assign wr_lo_w = wr_in && (addr_in == f_unit_addr(gi, `TCCU_OFF_VAL_LO));
            assign wr_hi_w = wr_in && (addr_in == f_unit_addr(gi, `TCCU_OFF_VAL_HI));

            // pin level feeds capture
            // Pad level is used whatever the pin direction, so port writes can capture
            assign srcs_w = {shared_src_w, unit_pin_in[gi]};
            assign raw_w = srcs_w[src_q];

            tccu_sync u_sync (
                .clock_in(clock_in),
                .srst_in(srst_in),
                .async_in(raw_w),
                .sync_out(sync_w)
            );

            assign rise_w = sync_w && !prev_q;
            assign fall_w = !sync_w && prev_q;

            // Edge history; a source switch may fake an edge
            always @(posedge clock_in) begin
                if (srst_in) begin
                    prev_q <= 1'b0;
                end else begin
                    prev_q <= sync_w;
                end
            end

            // only off, non-capture, reset or a completed group clears it
            tccu_presc u_presc (
                .clock_in(clock_in),
                .srst_in(srst_in),
                .clear_in(!en_w || !cap_mode_w),
                .edge_in(rise_w && active_w),
                .term_in((mode_w == `TCCU_MODE_CAP_RISE16) ? `TCCU_PRESC_TC16
                                                           : `TCCU_PRESC_TC4),
                .fire_out(presc_fire_w)
            );

            always @* begin
                case (mode_w)
                    `TCCU_MODE_CAP_FALL: cap_sel_w = fall_w;
                    `TCCU_MODE_CAP_RISE: cap_sel_w = rise_w;
                    `TCCU_MODE_CAP_RISE4: cap_sel_w = presc_fire_w;
                    `TCCU_MODE_CAP_RISE16: cap_sel_w = presc_fire_w;
                    default: cap_sel_w = 1'b0;
                endcase
            end

            assign cap_evt_w = en_w && cap_mode_w && active_w && cap_sel_w;

            assign match_now_w = (val_q == base_timer_count_in);
            // compare idle in sleep without timer
            assign match_evt_w = en_w && cmp_mode_w && active_w && match_now_w && !match_prev_q;

            // Edge of equality so a stalled timer yields one match
            always @(posedge clock_in) begin
                if (srst_in) begin
                    match_prev_q <= 1'b0;
                end else begin
                    match_prev_q <= match_now_w;
                end
            end

            // Control and source registers
            always @(posedge clock_in) begin
                if (srst_in) begin
                    ctrl_q <= `TCCU_CTRL_RST;
                    src_q <= `TCCU_SRC_RST;
                end else begin
                    if (wr_ctrl_w) begin
                        ctrl_q <= wdata_in & `TCCU_CTRL_WR_MASK;
                    end
                    if (wr_src_w) begin
                        src_q <= wdata_in[2:0];
                    end
                end
            end

            // overwrite without protection
            // A capture in the same cycle as a software write wins
            always @(posedge clock_in) begin
                if (srst_in) begin
                    val_q <= `TCCU_VAL_RST;
                end else if (cap_evt_w) begin
                    val_q <= base_timer_count_in;
                end else begin
                    if (wr_lo_w) begin
                        val_q[7:0] <= wdata_in;
                    end
                    if (wr_hi_w) begin
                        val_q[15:8] <= wdata_in;
                    end
                end
            end

            always @(posedge clock_in) begin
                if (srst_in) begin
                    latch_q <= 1'b0;
                end else if (wr_ctrl_w && (wdata_in == 8'h00)) begin
                    latch_q <= 1'b0;
                end else if (match_evt_w) begin
                    case (mode_w)
                        `TCCU_MODE_CMP_TOG_RST: latch_q <= !latch_q;
                        `TCCU_MODE_CMP_TOG: latch_q <= !latch_q;
                        `TCCU_MODE_CMP_SET: latch_q <= 1'b1;
                        `TCCU_MODE_CMP_CLR: latch_q <= 1'b0;
                        default: latch_q <= latch_q;
                    endcase
                end
            end

            // reset owed one edge after the match
            always @(posedge clock_in) begin
                if (srst_in) begin
                    rst_pend_q <= 1'b0;
                end else begin
                    rst_pend_q <= match_evt_w && ((mode_w == `TCCU_MODE_CMP_TOG_RST) ||
                                                  (mode_w == `TCCU_MODE_CMP_TRIG));
                end
            end

            assign event_w[gi] = cap_evt_w || match_evt_w;
            assign match_w[gi] = match_evt_w;
            assign rst_pend_w[gi] = rst_pend_q && match_now_w;
            assign latch_w[gi] = latch_q;
            assign ctrl_w[gi*8 +: 8] = {ctrl_q[7:6], latch_q, ctrl_q[4:0]};
            assign src_w[gi*3 +: 3] = src_q;
            assign val_w[gi*16 +: 16] = val_q;
        end
    endgenerate

    // ================================================================
    // Flags, enables and trigger select
    // ================================================================
    wire wr_flags_w = wr_in && (addr_in == `TCCU_ADDR_FLAGS);

    // sticky flags, write one to clear
    // A new event in the clearing cycle keeps its flag set
    always @(posedge clock_in) begin
        if (srst_in) begin
            flag_q <= 5'h00;
        end else if (wr_flags_w) begin
            flag_q <= (flag_q & ~wdata_in[4:0]) | event_w;
        end else begin
            flag_q <= flag_q | event_w;
        end
    end

    // Software-written configuration
    always @(posedge clock_in) begin
        if (srst_in) begin
            irq_en_q <= `TCCU_IRQ_EN_RST;
            trig_sel_q <= `TCCU_TRIG_SEL_RST;
        end else begin
            if (wr_in && (addr_in == `TCCU_ADDR_IRQ_EN)) begin
                irq_en_q <= wdata_in[4:0];
            end
            if (wr_in && (addr_in == `TCCU_ADDR_TRIG_SEL)) begin
                trig_sel_q <= wdata_in[2:0];
            end
        end
    end

    // ================================================================
    // Output pulses and levels
    // ================================================================

    always @(posedge clock_in) begin
        if (srst_in) begin
            adc_trig_q <= 1'b0;
            timer_rst_q <= 1'b0;
            irq_q <= 5'h00;
            wake_q <= 1'b0;
        end else begin
            adc_trig_q <= (trig_sel_q != 3'h0) && (trig_sel_q <= 3'h5) &&
                          match_w[trig_sel_q - 3'h1];
            // reset only if match still holds
            timer_rst_q <= |rst_pend_w;
            irq_q <= flag_q & irq_en_q;
            wake_q <= sleep_in && (|(flag_q & irq_en_q));
        end
    end

    // latch offered to pin routing and peripherals
    assign compare_out = latch_w;
    assign unit_event_flag_out = flag_q;
    assign irq_out = irq_q;
    assign wake_out = wake_q;
    assign adc_trigger_out = adc_trig_q;
    assign timer_reset_out = timer_rst_q;

    // ================================================================
    // Read port
    // ================================================================
    wire [2:0] rd_unit_w = addr_in[4:2];

    // Data stands in the cycle after the strobe only; unmapped reads zero
    always @(posedge clock_in) begin
        if (srst_in) begin
            rdata_q <= 8'h00;
        end else if (!rd_in) begin
            rdata_q <= 8'h00;
        end else if (rd_unit_w < 3'h5) begin
            case (addr_in[1:0])
                `TCCU_OFF_CTRL: rdata_q <= ctrl_w[rd_unit_w*8 +: 8];
                `TCCU_OFF_SRC: rdata_q <= {5'h00, src_w[rd_unit_w*3 +: 3]};
                `TCCU_OFF_VAL_LO: rdata_q <= val_w[rd_unit_w*16 +: 8];
                `TCCU_OFF_VAL_HI: rdata_q <= val_w[rd_unit_w*16 + 8 +: 8];
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            case (addr_in)
                `TCCU_ADDR_FLAGS: rdata_q <= {3'h0, flag_q};
                `TCCU_ADDR_IRQ_EN: rdata_q <= {3'h0, irq_en_q};
                `TCCU_ADDR_TRIG_SEL: rdata_q <= {5'h00, trig_sel_q};
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign rdata_out = rdata_q;
endmodule

//--- src/tccu_defs.vh
// Constants shared by the timer capture/compare unit design files
`ifndef TCCU_DEFS_VH
`define TCCU_DEFS_VH

// ====================================================================
// Geometry
// ====================================================================
`define TCCU_UNITS 5
`define TCCU_ADDR_W 5
`define TCCU_DATA_W 8

// ====================================================================
// Register map: unit n uses words n*4 .. n*4+3
// ====================================================================
`define TCCU_UNIT_STRIDE 5'h04
`define TCCU_OFF_CTRL 2'h0
`define TCCU_OFF_SRC 2'h1
`define TCCU_OFF_VAL_LO 2'h2
`define TCCU_OFF_VAL_HI 2'h3
`define TCCU_ADDR_FLAGS 5'h14
`define TCCU_ADDR_IRQ_EN 5'h15
`define TCCU_ADDR_TRIG_SEL 5'h16

// ====================================================================
// Control register fields
// ====================================================================
`define TCCU_CTRL_EN_BIT 7
`define TCCU_CTRL_OUT_BIT 5
`define TCCU_CTRL_FMT_BIT 4
`define TCCU_CTRL_WR_MASK 8'h9f
`define TCCU_CTRL_RST 8'h00
`define TCCU_SRC_RST 3'h0
`define TCCU_VAL_RST 16'h0000
`define TCCU_IRQ_EN_RST 5'h00
`define TCCU_TRIG_SEL_RST 3'h0

// ====================================================================
// Operating mode field encodings
// ====================================================================
`define TCCU_MODE_OFF 4'h0
`define TCCU_MODE_CMP_TOG_RST 4'h1
`define TCCU_MODE_CMP_TOG 4'h2
`define TCCU_MODE_CAP_FALL 4'h4
`define TCCU_MODE_CAP_RISE 4'h5
`define TCCU_MODE_CAP_RISE4 4'h6
`define TCCU_MODE_CAP_RISE16 4'h7
`define TCCU_MODE_CMP_SET 4'h8
`define TCCU_MODE_CMP_CLR 4'h9
`define TCCU_MODE_CMP_SWI 4'ha
`define TCCU_MODE_CMP_TRIG 4'hb

// ====================================================================
// Prescaler terminal counts (edges minus one)
// ====================================================================
`define TCCU_PRESC_TC4 4'h3
`define TCCU_PRESC_TC16 4'hf

`endif

//--- src/tccu_sync.v
// Two-flop synchroniser for one capture source level
`timescale 1ns/1ps

module tccu_sync (
    input wire clock_in,
    input wire srst_in,
    input wire async_in,
    output wire sync_out
);
    // ================================================================
    // Synchroniser chain
    // ================================================================
    reg meta_q; // First stage, read only by the second
    reg sync_q; // Second stage, safe to use

    // Two stages bound metastability to a negligible rate
    always @(posedge clock_in) begin
        if (srst_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

//--- src/tccu_presc.v
// Capture edge prescaler: fires on every Nth rising edge
`timescale 1ns/1ps
`include "tccu_defs.vh"

module tccu_presc (
    input wire clock_in,
    input wire srst_in,
    input wire clear_in,
    input wire edge_in,
    input wire [3:0] term_in,
    output wire fire_out
);
    // ================================================================
    // Edge counter
    // ================================================================
    reg [3:0] count_q; // Edges seen since last fire

    // Fires combinationally on the edge that completes the group
    assign fire_out = edge_in && (count_q == term_in);

    // Counter is not cleared by a change of term alone
    always @(posedge clock_in) begin
        if (srst_in || clear_in) begin
            count_q <= 4'h0;
        end else if (fire_out) begin
            count_q <= 4'h0;
        end else if (edge_in) begin
            count_q <= count_q + 4'h1;
        end
    end
endmodule

//--- bench/tccu_assertions.sv
// Port checker for the capture/compare units
`timescale 1ns/1ps
module tccu_chk (
    input wire clock_in,
    input wire srst_in,
    input wire [4:0] addr_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire sleep_in,
    input wire [4:0] unit_event_flag_out,
    input wire [4:0] irq_out,
    input wire wake_out,
    input wire adc_trigger_out,
    input wire timer_reset_out
);
    // ==========
    // Port relations, one clock domain
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    a_rd_quiet: assert property (
        !$past(rd_in) |-> rdata_out == 8'h00) else $error("read data outside slot");
    a_unmapped_zero: assert property (
        rd_in && addr_in > 5'h16 |=> rdata_out == 8'h00) else $error("unmapped read");
    a_irq_needs_flag: assert property (
        (irq_out & ~$past(unit_event_flag_out)) == 5'h00) else $error("irq without flag");
    a_flag_sticky: assert property (
        |($past(unit_event_flag_out) & ~unit_event_flag_out)
        |-> $past(wr_in && addr_in == 5'h14)) else $error("flag dropped alone");
    a_trig_with_flag: assert property (
        adc_trigger_out |-> |unit_event_flag_out) else $error("trigger without flag");
    a_trig_pulse: assert property (
        adc_trigger_out |=> !adc_trigger_out) else $error("trigger too long");
    a_trst_after_match: assert property (
        timer_reset_out |-> $past(|unit_event_flag_out)) else $error("stray timer reset");
    a_wake_cause: assert property (
        wake_out |-> $past(sleep_in) && $past(|unit_event_flag_out)) else $error("bad wake");
endmodule
bind tccu_top tccu_chk u_chk (.*);

//--- bench/tccu_timer_model.sv
// Base timer model facing the units
`timescale 1ns/1ps
module tccu_timer_model (
    input wire clock_in,
    input wire srst_in,
    input wire load_in,
    input wire [15:0] load_val_in,
    input wire clear_in,
    output reg [15:0] count_out
);
    // ==========
    // Count held still so captures are exact
    // same clock as the units
    // cleared only by reset or the unit pulse
    always @(posedge clock_in) begin
        if (srst_in || clear_in) begin
            count_out <= 16'h0000;
        end else if (load_in) begin
            count_out <= load_val_in;
        end
    end
endmodule

//--- bench/tccu_tb_top.sv
// Self-checking bench for the capture/compare units
`timescale 1ns/1ps
module tccu_tb_top;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic [4:0] addr_in = 5'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic timer_running_in = 1'b1;
    logic sleep_in = 1'b0;
    logic [7:0] src_v = 8'h00; // Source levels
    logic tm_load = 1'b0;
    logic [15:0] tm_val = 16'h0000;
    int error_cnt = 0;
    int checks = 0;
    int trig_cnt = 0;
    int rst_cnt = 0;
    wire [15:0] base_timer_count_in;
    wire [7:0] rdata_out;
    wire [4:0] unit_pin_in, compare_out, unit_event_flag_out, irq_out;
    wire wake_out, adc_trigger_out, timer_reset_out;
    wire comparator_one_sync_out_in, comparator_two_sync_out_in;
    wire pin_change_interrupt_in, logic_cell_one_out_in, logic_cell_two_out_in;
    wire logic_cell_three_out_in, logic_cell_four_out_in;
    // unit pin kept an input for capture
    assign unit_pin_in = {5{src_v[0]}};
    assign {logic_cell_four_out_in, logic_cell_three_out_in, logic_cell_two_out_in,
        logic_cell_one_out_in, pin_change_interrupt_in, comparator_two_sync_out_in,
        comparator_one_sync_out_in} = src_v[7:1];
    tccu_top dut (.*);
    tccu_timer_model tmr (.clock_in(clock_in), .srst_in(srst_in), .load_in(tm_load),
        .load_val_in(tm_val), .clear_in(timer_reset_out), .count_out(base_timer_count_in));
    initial begin
        forever #2 clock_in = ~clock_in;
    end
    // Pulse counters
    always @(posedge clock_in) begin
        trig_cnt <= trig_cnt + int'(adc_trigger_out);
        rst_cnt <= rst_cnt + int'(timer_reset_out);
    end
    // ==========
    // Shared tasks
    task chk(input [15:0] got, input [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task wr(input [4:0] a, input [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    task rd(input [4:0] a, input [7:0] e);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, e);
    endtask
    task tload(input [15:0] v);
        @(posedge clock_in);
        tm_val <= v;
        tm_load <= 1'b1;
        @(posedge clock_in);
        tm_load <= 1'b0;
    endtask
    // Rise then fall on one source, long enough for the synchroniser
    task pulse(input int s);
        @(posedge clock_in) src_v[s] <= 1'b1;
        cyc(3);
        @(posedge clock_in) src_v[s] <= 1'b0;
        cyc(5);
    endtask
    task end_sim();
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========
    // Scenarios
    task t_regs();
        for (int u = 0; u < 5; u++) begin
            rd(5'(u * 4), 8'h00);
            wr(5'(u * 4), 8'hff);
            rd(5'(u * 4), 8'h9f);
            wr(5'(u * 4), 8'h00);
        end
        wr(5'h1f, 8'hff);
        rd(5'h1f, 8'h00);
    endtask
    task t_cap();
        for (int s = 0; s < 8; s++) begin
            wr(5'h05, 8'(s));
            wr(5'h04, 8'h85);
            wr(5'h14, 8'h02);
            tload(16'ha5c0 + 16'(s));
            pulse(s);
            chk(unit_event_flag_out, 16'h0002);
            rd(5'h06, 8'hc0 + 8'(s));
            rd(5'h07, 8'ha5);
            wr(5'h04, 8'h00);
        end
    endtask
    task t_fall();
        wr(5'h05, 8'h00);
        wr(5'h04, 8'h84);
        wr(5'h14, 8'h02);
        tload(16'h1111);
        @(posedge clock_in) src_v[0] <= 1'b1;
        cyc(5);
        chk(unit_event_flag_out, 16'h0000);
        @(posedge clock_in) src_v[0] <= 1'b0;
        cyc(5);
        tload(16'h2222);
        pulse(0);
        rd(5'h06, 8'h22);
        chk(unit_event_flag_out, 16'h0002);
        wr(5'h04, 8'h00);
    endtask
    task t_presc();
        for (int k = 0; k < 2; k++) begin
            wr(5'h04, k ? 8'h87 : 8'h86);
            pulse(0);
            pulse(0);
            wr(5'h04, 8'h00);
            wr(5'h04, k ? 8'h87 : 8'h86);
            wr(5'h14, 8'h02);
            for (int i = 1; i <= (k ? 16 : 4); i++) begin
                pulse(0);
                chk(unit_event_flag_out[1], i == (k ? 16 : 4));
            end
        end
        wr(5'h04, 8'h00);
    endtask
    task t_cmp();
        logic [23:0] md = 24'hab1289; // Modes in order, low nibble first
        logic [5:0] lat = 6'b111010; // Latch after each match
        logic [5:0] rs = 6'b011000; // Timer reset expected
        int nt, nr;
        wr(5'h16, 8'h03);
        wr(5'h0a, 8'h34);
        wr(5'h0b, 8'h12);
        for (int i = 0; i < 6; i++) begin
            tload(16'h0000);
            wr(5'h08, {4'h8, md[i * 4 +: 4]});
            wr(5'h14, 8'h04);
            nt = trig_cnt;
            nr = rst_cnt;
            tload(16'h1234);
            cyc(4);
            chk(compare_out[2], lat[i]);
            chk(unit_event_flag_out[2], 1'b1);
            chk(16'(trig_cnt - nt), 16'h0001);
            chk(16'(rst_cnt - nr), rs[i]);
        end
        // Value moved in the trigger cycle cancels the timer reset
        tload(16'h0000);
        wr(5'h08, 8'h8b);
        wr(5'h14, 8'h04);
        nt = trig_cnt;
        nr = rst_cnt;
        fork
            tload(16'h1234);
            begin
                @(posedge clock_in);
                #1 wr(5'h0a, 8'h35);
            end
        join
        cyc(4);
        chk(16'(trig_cnt - nt), 16'h0001);
        chk(16'(rst_cnt - nr), 16'h0000);
        chk(unit_event_flag_out[2], 1'b1);
        wr(5'h08, 8'h00);
        #1 chk(compare_out[2], 1'b0);
    endtask
    task t_sleep();
        wr(5'h15, 8'h02);
        wr(5'h04, 8'h85);
        wr(5'h14, 8'h02);
        @(posedge clock_in);
        sleep_in <= 1'b1;
        timer_running_in <= 1'b0;
        pulse(0);
        chk(unit_event_flag_out[1], 1'b0);
        @(posedge clock_in) timer_running_in <= 1'b1;
        pulse(0);
        chk(irq_out[1], 1'b1);
        chk(wake_out, 1'b1);
        wr(5'h15, 8'h00);
        cyc(2);
        chk(irq_out[1], 1'b0);
    endtask
    initial begin
        repeat (2) @(posedge clock_in);
        srst_in <= 1'b0;
        t_regs();
        t_cap();
        t_fall();
        t_presc();
        t_cmp();
        t_sleep();
        end_sim();
    end
    // Watchdog well beyond the expected run
    initial begin
        #60000;
        error_cnt++;
        end_sim();
    end
endmodule
